// ===== hw/rst_clk_pkg.sv
// Constants shared by the reset sequencer and clock-source configuration block
package rst_clk_pkg;

    // Register port geometry
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;

    // Register offsets
    localparam logic [ADDR_W-1:0] PUDR_OFFSET   = 4'h0;
    localparam logic [ADDR_W-1:0] OSC_CFG_OFFSET = 4'h4;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h8;
    localparam logic [ADDR_W-1:0] CAUSE_OFFSET  = 4'hC;

    // Pull-up disable register fields
    localparam int PUD_RESET_BIT = 0;
    localparam int PUD_BSTRAP_BIT = 1;
    localparam int PUD_EMI_BIT   = 2;
    localparam logic [DATA_W-1:0] PUDR_RESET_VAL = 16'h0000;
    localparam logic [DATA_W-1:0] PUDR_WR_MASK   = 16'h0007;

    // Oscillator control register fields (no relaxation oscillator fields)
    localparam int OSC_HL_BIT = 0;
    localparam logic [DATA_W-1:0] OSC_CFG_RESET_VAL = 16'h0000;
    localparam logic [DATA_W-1:0] OSC_CFG_WR_MASK   = 16'h0001;

    // Status register fields (read only)
    localparam int ST_BOOT_EXT  = 0;
    localparam int ST_BOOT_EMI  = 1;
    localparam int ST_SECURED   = 2;
    localparam int ST_CLK_MODE  = 3;
    localparam int ST_DEBUG_RST = 4;

    // Reset cause register fields (write one to clear)
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_PIN = 1;

    // Straps tied low inside the part
    localparam logic OFFCHIP_BOOT_TIE = 1'b0;
    localparam logic MEM_IF_MODE_TIE  = 1'b0;

    // Internal clock cycles counted before internal reset is released
    localparam int RELEASE_CYCLES_DEFAULT = 32;

    // Synchronised pin vector positions
    localparam int PIN_RESET_N  = 0;
    localparam int PIN_TRST_N   = 1;
    localparam int PIN_SECURED  = 2;
    localparam int PIN_CLK_MODE = 3;
    localparam int PIN_COUNT    = 4;

    // Reset sequencer states
    typedef enum logic [1:0] {
        SEQ_POWER_ON = 2'b00,
        SEQ_HOLD     = 2'b01,
        SEQ_COUNT    = 2'b10,
        SEQ_RUN      = 2'b11
    } seq_state_e;

endpackage : rst_clk_pkg

// ===== hw/pin_sync.sv
// Two-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int          WIDTH     = 4,
    parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stable_reg;

    generate
        if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
            $error("pin_sync: WIDTH must lie in 1..32");
        end
    endgenerate

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg   <= RESET_VAL[WIDTH-1:0];
            stable_reg <= RESET_VAL[WIDTH-1:0];
        end else begin
            meta_reg   <= async_in;
            stable_reg <= meta_reg;
        end
    end

    assign sync_out = stable_reg;

endmodule : pin_sync
`default_nettype wire

// ===== hw/release_counter.sv
// Down counter that times the hold-off before internal reset is released
`timescale 1ns/10ps
`default_nettype none
module release_counter #(
    parameter int CYCLES = 32,
    parameter int CNT_W  = $clog2(CYCLES + 1)
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic load,
    output logic      done
);

    localparam logic [CNT_W-1:0] LOAD_VAL = CNT_W'(CYCLES);
    localparam logic [CNT_W-1:0] ZERO     = '0;
    localparam logic [CNT_W-1:0] ONE      = CNT_W'(1);

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;

    generate
        if (CYCLES < 1) begin : g_bad_cycles
            $error("release_counter: CYCLES must be at least 1");
        end
    endgenerate

    // Reload while held, then count down to zero and stop
    assign count_next = load ? LOAD_VAL : ((count_reg == ZERO) ? ZERO : count_reg - ONE);
    assign done       = (count_reg == ZERO) && !load;

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= LOAD_VAL;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule : release_counter
`default_nettype wire

// ===== hw/reset_and_clock_source_cfg.sv
// Reset sequencer, boot strap handling and oscillator source configuration
//
// Notes on behaviour
// - External reset pin low clears the writable registers and holds internal reset high.
// - Reset pin alone leaves the debug logic running; debug reset follows test reset.
// - Power-on reset asserts internal reset regardless of the reset pin.
// - Writing one to the reset-pin pull-up disable bit turns its pull-up off.
// - Reset status output always follows the internal reset state.
// - Boot off-chip only when off-chip strap is high and flash is not secured.
// - Normal boot is internal; interface mode strap counts only with off-chip boot.
// - Off-chip boot strap and interface mode strap are tied low inside.
// - Oscillator level-select bit reads zero after reset.
// - No relaxation oscillator, and no register fields for one.
`timescale 1ns/10ps
`default_nettype none
module reset_and_clock_source_cfg
    import rst_clk_pkg::*;
#(
    parameter int RELEASE_CYCLES = RELEASE_CYCLES_DEFAULT
) (
    input  wire logic              CLOCK,
    input  wire logic              SYS_RST,
    input  wire logic              EXT_RESET_N,
    input  wire logic              TEST_RESET_N,
    input  wire logic              FLASH_SECURED,
    input  wire logic              EXTERNAL_CLOCK_MODE_SELECT,
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic [DATA_W-1:0] REG_WDATA,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    output logic      [DATA_W-1:0] REG_RDATA,
    output logic                   INTERNAL_RESET,
    output logic                   CHIP_RESET_STATUS_OUT,
    output logic                   DEBUG_RESET,
    output logic                   RESET_PULLUP_DISABLE,
    output logic                   BOOT_STRAP_PULLUP_DISABLE,
    output logic                   MODE_STRAP_PULLUP_DISABLE,
    output logic                   OSC_HIGH_LEVEL_BIT,
    output logic                   EXTERNAL_CLOCK_SELECTED,
    output logic                   BOOT_OFFCHIP,
    output logic                   BOOT_WIDE_INTERFACE
);

    // Parameter check: the counter cannot time zero cycles
    generate
        if (RELEASE_CYCLES < 1) begin : g_bad_release
            $error("reset_and_clock_source_cfg: RELEASE_CYCLES must be at least 1");
        end
    endgenerate

    // Register field helper: keep only writable bits
    function automatic logic [DATA_W-1:0] masked_write(
        input logic [DATA_W-1:0] wdata,
        input logic [DATA_W-1:0] mask
    );
        masked_write = wdata & mask;
    endfunction : masked_write

    // Address match helper used by both strobes
    function automatic logic hit(
        input logic              strobe,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] offset
    );
        hit = strobe && (addr == offset);
    endfunction : hit

    // Synchronised pins
    logic [PIN_COUNT-1:0] pins_async;
    logic [PIN_COUNT-1:0] pins_sync;
    logic                 pin_reset_low;
    logic                 trst_low;
    logic                 secured_sync;
    logic                 clk_mode_sync;

    // Sequencer
    seq_state_e state_reg;
    seq_state_e state_next;
    logic       count_load;
    logic       count_done;
    logic       int_rst_reg;
    logic       int_rst_next;
    logic       reg_clear;
    logic       enter_run;
    logic       pin_event;

    // Registers
    logic [DATA_W-1:0] pudr_reg;
    logic [DATA_W-1:0] pudr_next;
    logic [DATA_W-1:0] osc_cfg_reg;
    logic [DATA_W-1:0] osc_cfg_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] cause_word;
    logic              por_seen_reg;
    logic              por_seen_next;
    logic              pin_seen_reg;
    logic              pin_seen_next;
    logic              boot_ext_reg;
    logic              boot_ext_next;
    logic              boot_emi_reg;
    logic              boot_emi_next;
    logic              secured_reg;
    logic              secured_next;
    logic              debug_rst_reg;
    logic              clk_mode_reg;

    // Decoded strobes
    logic wr_pudr;
    logic wr_osc_cfg;
    logic wr_cause;
    logic rd_pudr;
    logic rd_osc_cfg;
    logic rd_status;
    logic rd_cause;

    // Pin inputs pass two flops before any logic sees them
    assign pins_async[PIN_RESET_N] = EXT_RESET_N;
    assign pins_async[PIN_TRST_N]  = TEST_RESET_N;
    assign pins_async[PIN_SECURED] = FLASH_SECURED;
    assign pins_async[PIN_CLK_MODE] = EXTERNAL_CLOCK_MODE_SELECT;

    pin_sync #(
        .WIDTH     (PIN_COUNT),
        .RESET_VAL (32'((1 << PIN_RESET_N) | (1 << PIN_TRST_N))) // Reset lines idle high
    ) u_pin_sync (
        .clk      (CLOCK),
        .rst      (SYS_RST),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    assign pin_reset_low = !pins_sync[PIN_RESET_N];
    assign trst_low      = !pins_sync[PIN_TRST_N];
    assign secured_sync  = pins_sync[PIN_SECURED];
    assign clk_mode_sync = pins_sync[PIN_CLK_MODE];

    // Hold-off counter reloads while reset is requested
    assign count_load = (state_reg == SEQ_POWER_ON) || (state_reg == SEQ_HOLD) || pin_reset_low;

    release_counter #(
        .CYCLES (RELEASE_CYCLES)
    ) u_release_counter (
        .clk  (CLOCK),
        .rst  (SYS_RST),
        .load (count_load),
        .done (count_done)
    );

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SEQ_POWER_ON: begin
                state_next = SEQ_HOLD;
            end
            SEQ_HOLD: begin
                if (!pin_reset_low) begin
                    state_next = SEQ_COUNT;
                end
            end
            SEQ_COUNT: begin
                if (pin_reset_low) begin
                    state_next = SEQ_HOLD;
                end else if (count_done) begin
                    state_next = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (pin_reset_low) begin
                    state_next = SEQ_HOLD;
                end
            end
            default: begin
                state_next = SEQ_POWER_ON;
            end
        endcase
    end

    // Internal reset is high in every state but run, changed only on a clock edge
    assign int_rst_next = (state_next != SEQ_RUN);
    assign enter_run    = (state_reg == SEQ_COUNT) && (state_next == SEQ_RUN);
    assign pin_event    = (state_reg != SEQ_HOLD) && (state_next == SEQ_HOLD) && pin_reset_low;

    // Sequencer state and internal reset flop
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            state_reg   <= SEQ_POWER_ON;
            int_rst_reg <= 1'b1;
        end else begin
            state_reg   <= state_next;
            int_rst_reg <= int_rst_next;
        end
    end

    // Writable registers are cleared by power-on or internal reset
    assign reg_clear = SYS_RST || int_rst_reg;

    // Debug logic reset follows only power-on and test reset
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            debug_rst_reg <= 1'b1;
        end else begin
            debug_rst_reg <= trst_low;
        end
    end

    // Boot mode is sampled at the moment internal reset releases
    assign boot_ext_next = enter_run ? (OFFCHIP_BOOT_TIE && !secured_sync) : boot_ext_reg;
    assign boot_emi_next = enter_run ? (OFFCHIP_BOOT_TIE && !secured_sync && MEM_IF_MODE_TIE) : boot_emi_reg;
    assign secured_next  = enter_run ? secured_sync : secured_reg;

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            boot_ext_reg <= 1'b0;
            boot_emi_reg <= 1'b0;
            secured_reg  <= 1'b0;
        end else begin
            boot_ext_reg <= boot_ext_next;
            boot_emi_reg <= boot_emi_next;
            secured_reg  <= secured_next;
        end
    end

    // Address decode
    assign wr_pudr   = hit(REG_WR, REG_ADDR, PUDR_OFFSET);
    assign wr_osc_cfg = hit(REG_WR, REG_ADDR, OSC_CFG_OFFSET);
    assign wr_cause  = hit(REG_WR, REG_ADDR, CAUSE_OFFSET);
    assign rd_pudr   = hit(REG_RD, REG_ADDR, PUDR_OFFSET);
    assign rd_osc_cfg = hit(REG_RD, REG_ADDR, OSC_CFG_OFFSET);
    assign rd_status = hit(REG_RD, REG_ADDR, STATUS_OFFSET);
    assign rd_cause  = hit(REG_RD, REG_ADDR, CAUSE_OFFSET);

    // Writable registers; only the level-select bit exists in oscillator control
    assign pudr_next  = wr_pudr ? masked_write(REG_WDATA, PUDR_WR_MASK) : pudr_reg;
    assign osc_cfg_next = wr_osc_cfg ? masked_write(REG_WDATA, OSC_CFG_WR_MASK) : osc_cfg_reg;

    always_ff @(posedge CLOCK) begin
        if (reg_clear) begin
            pudr_reg    <= PUDR_RESET_VAL;
            osc_cfg_reg <= OSC_CFG_RESET_VAL;
        end else begin
            pudr_reg    <= pudr_next;
            osc_cfg_reg <= osc_cfg_next;
        end
    end

    // Reset cause flags: hardware set wins over a write-one clear
    assign por_seen_next = (wr_cause && REG_WDATA[CAUSE_POR]) ? 1'b0 : por_seen_reg;
    assign pin_seen_next = pin_event || (pin_seen_reg && !(wr_cause && REG_WDATA[CAUSE_PIN]));

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            por_seen_reg <= 1'b1;
            pin_seen_reg <= 1'b0;
        end else begin
            por_seen_reg <= por_seen_next;
            pin_seen_reg <= pin_seen_next;
        end
    end

    // Clock-mode pin level, registered for the output
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            clk_mode_reg <= 1'b0;
        end else begin
            clk_mode_reg <= clk_mode_sync;
        end
    end

    // Read-only words
    always_comb begin
        status_word               = '0;
        status_word[ST_BOOT_EXT]  = boot_ext_reg;
        status_word[ST_BOOT_EMI]  = boot_emi_reg;
        status_word[ST_SECURED]   = secured_reg;
        status_word[ST_CLK_MODE]  = clk_mode_reg;
        status_word[ST_DEBUG_RST] = debug_rst_reg;
        cause_word                = '0;
        cause_word[CAUSE_POR]     = por_seen_reg;
        cause_word[CAUSE_PIN]     = pin_seen_reg;
    end

    // Read data mux; unmapped offsets and idle cycles give zero
    assign rdata_next = rd_pudr   ? pudr_reg    :
                        rd_osc_cfg ? osc_cfg_reg :
                        rd_status ? status_word :
                        rd_cause  ? cause_word  : '0;

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Outputs straight from flops
    assign REG_RDATA                 = rdata_reg;
    assign INTERNAL_RESET            = int_rst_reg;
    assign CHIP_RESET_STATUS_OUT     = int_rst_reg;
    assign DEBUG_RESET               = debug_rst_reg;
    assign RESET_PULLUP_DISABLE      = pudr_reg[PUD_RESET_BIT];
    assign BOOT_STRAP_PULLUP_DISABLE = pudr_reg[PUD_BSTRAP_BIT];
    assign MODE_STRAP_PULLUP_DISABLE = pudr_reg[PUD_EMI_BIT];
    assign OSC_HIGH_LEVEL_BIT        = osc_cfg_reg[OSC_HL_BIT];
    assign EXTERNAL_CLOCK_SELECTED   = clk_mode_reg;
    assign BOOT_OFFCHIP              = boot_ext_reg;
    assign BOOT_WIDE_INTERFACE       = boot_emi_reg;

endmodule : reset_and_clock_source_cfg
`default_nettype wire

// ===== tb/board_reset_model.sv
// Board reset source, debugger and clock-source pins facing the block
`timescale 1ns/10ps
`default_nettype none
module board_reset_model (
    input  wire logic clock,
    output logic      ext_reset_n,
    output logic      test_reset_n,
    output logic      flash_secured,
    output logic      ext_clk_mode
);
    // Pins idle inactive: reset lines pulled up, resonator clocking
    initial begin
        ext_reset_n   = 1'b1;
        test_reset_n  = 1'b1;
        flash_secured = 1'b0;
        ext_clk_mode  = 1'b0;
    end

    // Hold the reset pin, and test reset too when asked, for some cycles
    task automatic pulse(input logic ext, input logic tst, input int cycles);
        @(posedge clock);
        ext_reset_n  <= ~ext;
        test_reset_n <= ~tst;
        repeat (cycles) @(posedge clock);
        ext_reset_n  <= 1'b1;
        test_reset_n <= 1'b1;
    endtask : pulse

    // Security level and clock-mode pin, changed just after an edge
    task automatic set_pins(input logic secured, input logic ext_clk);
        @(posedge clock);
        flash_secured <= secured;
        ext_clk_mode  <= ext_clk;
    endtask : set_pins
endmodule : board_reset_model
`default_nettype wire

// ===== tb/rst_clk_sva.sv
// Concurrent checks on the ports of the reset and clock-source block
`timescale 1ns/10ps
`default_nettype none
module rst_clk_sva
    import rst_clk_pkg::*;
#(
    parameter int RELEASE_CYCLES = RELEASE_CYCLES_DEFAULT
) (
    input wire logic              CLOCK,
    input wire logic              SYS_RST,
    input wire logic              EXT_RESET_N,
    input wire logic              TEST_RESET_N,
    input wire logic              EXTERNAL_CLOCK_MODE_SELECT,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic              REG_WR,
    input wire logic              REG_RD,
    input wire logic [DATA_W-1:0] REG_RDATA,
    input wire logic              INTERNAL_RESET,
    input wire logic              CHIP_RESET_STATUS_OUT,
    input wire logic              DEBUG_RESET,
    input wire logic              RESET_PULLUP_DISABLE,
    input wire logic              OSC_HIGH_LEVEL_BIT,
    input wire logic              EXTERNAL_CLOCK_SELECTED,
    input wire logic              BOOT_OFFCHIP,
    input wire logic              BOOT_WIDE_INTERFACE
);
    localparam int REL_MAX = RELEASE_CYCLES + 8;
    logic [9:0] high_cnt_reg;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    // Cycles the reset pin has stayed high since the last reset
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || !EXT_RESET_N) begin
            high_cnt_reg <= 10'h000;
        end else if (high_cnt_reg != 10'h3FF) begin
            high_cnt_reg <= high_cnt_reg + 10'h001;
        end
    end

    property p_status_follows;
        CHIP_RESET_STATUS_OUT == INTERNAL_RESET;
    endproperty
    a_status_follows: assert property (p_status_follows) else $error("status output differs");
    property p_por;
        $fell(SYS_RST) |-> INTERNAL_RESET && DEBUG_RESET && !OSC_HIGH_LEVEL_BIT && !RESET_PULLUP_DISABLE;
    endproperty
    a_por: assert property (p_por) else $error("power-on state wrong");
    property p_pin_reset;
        !EXT_RESET_N [*3] |=> INTERNAL_RESET;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset not taken");
    property p_release_wait;
        $fell(INTERNAL_RESET) |-> high_cnt_reg >= RELEASE_CYCLES + 2 && high_cnt_reg <= RELEASE_CYCLES + 6;
    endproperty
    a_release_wait: assert property (p_release_wait) else $error("release count wrong");
    property p_release_bound;
        $rose(EXT_RESET_N) |-> ##[1:REL_MAX] !INTERNAL_RESET;
    endproperty
    a_release_bound: assert property (p_release_bound) else $error("release too late");
    property p_debug;
        TEST_RESET_N [*3] |=> !DEBUG_RESET;
    endproperty
    a_debug: assert property (p_debug) else $error("debug reset without test reset");
    property p_pudr_write;
        REG_WR && REG_ADDR == PUDR_OFFSET && !INTERNAL_RESET |=>
            RESET_PULLUP_DISABLE == $past(REG_WDATA[PUD_RESET_BIT]);
    endproperty
    a_pudr_write: assert property (p_pudr_write) else $error("pull-up disable not written");
    property p_osc_read;
        REG_RD && REG_ADDR == OSC_CFG_OFFSET |=> REG_RDATA == {{(DATA_W-1){1'b0}}, OSC_HIGH_LEVEL_BIT};
    endproperty
    a_osc_read: assert property (p_osc_read) else $error("oscillator read wrong");
    property p_boot_internal;
        !BOOT_OFFCHIP && !BOOT_WIDE_INTERFACE;
    endproperty
    a_boot_internal: assert property (p_boot_internal) else $error("boot not internal");
    property p_clock_mode;
        EXTERNAL_CLOCK_MODE_SELECT [*4] |=> EXTERNAL_CLOCK_SELECTED;
    endproperty
    a_clock_mode: assert property (p_clock_mode) else $error("clock mode not seen");
endmodule : rst_clk_sva

bind reset_and_clock_source_cfg rst_clk_sva #(.RELEASE_CYCLES(RELEASE_CYCLES)) rst_clk_sva_i (.*);
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the reset sequencer and clock-source block
`timescale 1ns/10ps
`default_nettype none
`define check(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module tb;
    import rst_clk_pkg::*;
    localparam int RC = 4;
    logic              clock = 1'b0;
    logic              sys_rst = 1'b1;
    logic              ext_reset_n, test_reset_n, flash_secured, ext_clk_mode;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 16'h0000;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic              internal_reset, status_out, debug_reset, pud_reset, pud_boot, pud_mode;
    logic              osc_hl, ext_clk_sel, boot_offchip, boot_wide;
    int                errors = 0;
    int                n_compared = 0;

    // Free-running 10 MHz clock
    always #50 clock = ~clock;

    reset_and_clock_source_cfg #(.RELEASE_CYCLES(RC)) reset_and_clock_source_cfg_i (
        .CLOCK(clock), .SYS_RST(sys_rst), .EXT_RESET_N(ext_reset_n), .TEST_RESET_N(test_reset_n),
        .FLASH_SECURED(flash_secured), .EXTERNAL_CLOCK_MODE_SELECT(ext_clk_mode),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .INTERNAL_RESET(internal_reset), .CHIP_RESET_STATUS_OUT(status_out),
        .DEBUG_RESET(debug_reset), .RESET_PULLUP_DISABLE(pud_reset), .BOOT_STRAP_PULLUP_DISABLE(pud_boot),
        .MODE_STRAP_PULLUP_DISABLE(pud_mode), .OSC_HIGH_LEVEL_BIT(osc_hl),
        .EXTERNAL_CLOCK_SELECTED(ext_clk_sel), .BOOT_OFFCHIP(boot_offchip), .BOOT_WIDE_INTERFACE(boot_wide)
    );

    board_reset_model board_reset_model_i (
        .clock(clock), .ext_reset_n(ext_reset_n), .test_reset_n(test_reset_n),
        .flash_secured(flash_secured), .ext_clk_mode(ext_clk_mode)
    );

    task automatic give_verdict;
        $display("comparisons %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    // One-cycle register write
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    // One-cycle read, data judged in the following cycle
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        `check("read data", exp, reg_rdata)
    endtask : rd_chk

    // Bounded wait for internal reset to drop, judging the count
    task automatic wait_release(input int start);
        int n;
        n = start;
        while (internal_reset !== 1'b0 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
        `check("release cycles", 1'b1, n >= RC + 2 && n <= RC + 5)
        `check("status out", 1'b0, status_out)
        if (n >= 200) begin
            give_verdict();
        end
    endtask : wait_release

    task automatic t_power_on;
        #1;
        `check("internal reset", 1'b1, internal_reset)
        `check("debug reset", 1'b1, debug_reset)
        wr(OSC_CFG_OFFSET, 16'h0001);
        wait_release(2);
        rd_chk(OSC_CFG_OFFSET, 16'h0000);
        rd_chk(PUDR_OFFSET, 16'h0000);
        rd_chk(CAUSE_OFFSET, 16'h0001);
        wr(CAUSE_OFFSET, 16'h0001);
        rd_chk(CAUSE_OFFSET, 16'h0000);
    endtask : t_power_on

    task automatic t_pullups;
        wr(PUDR_OFFSET, 16'hFFFF);
        #1;
        `check("pull-ups off", 3'h7, {pud_mode, pud_boot, pud_reset})
        rd_chk(PUDR_OFFSET, 16'h0007);
        wr(PUDR_OFFSET, 16'h0004);
        #1;
        `check("mode strap pull-up only", 3'h4, {pud_mode, pud_boot, pud_reset})
    endtask : t_pullups

    task automatic t_osc;
        wr(OSC_CFG_OFFSET, 16'hFFFF);
        rd_chk(OSC_CFG_OFFSET, 16'h0001);
        `check("level select", 1'b1, osc_hl)
        wr(OSC_CFG_OFFSET, 16'h0000);
        rd_chk(OSC_CFG_OFFSET, 16'h0000);
        rd_chk(4'h2, 16'h0000);
    endtask : t_osc

    task automatic t_ext_clock;
        board_reset_model_i.set_pins(1'b0, 1'b1);
        wr(OSC_CFG_OFFSET, 16'h0001);
        repeat (4) @(posedge clock);
        #1;
        `check("external clock", 1'b1, ext_clk_sel)
        rd_chk(STATUS_OFFSET, 16'h0008);
        board_reset_model_i.set_pins(1'b0, 1'b0);
    endtask : t_ext_clock

    task automatic t_pin_reset(input logic with_test);
        wr(OSC_CFG_OFFSET, 16'h0001);
        board_reset_model_i.pulse(1'b1, with_test, 6);
        #1;
        `check("internal reset", 1'b1, internal_reset)
        `check("status out", 1'b1, status_out)
        `check("debug reset", with_test, debug_reset)
        `check("level select", 1'b0, osc_hl)
        wait_release(0);
        rd_chk(STATUS_OFFSET, 16'h0000);
        rd_chk(CAUSE_OFFSET, 16'h0002);
        wr(CAUSE_OFFSET, 16'h0002);
        rd_chk(CAUSE_OFFSET, 16'h0000);
    endtask : t_pin_reset

    task automatic t_boot;
        for (int s = 0; s < 2; s++) begin
            board_reset_model_i.set_pins(1'(s), 1'b0);
            board_reset_model_i.pulse(1'b1, 1'b0, 4);
            wait_release(0);
            `check("boot straps", 2'h0, {boot_wide, boot_offchip})
            rd_chk(STATUS_OFFSET, {13'h0000, 1'(s), 2'h0});
        end
    endtask : t_boot

    // Main sequence
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        t_power_on();
        t_pullups();
        t_osc();
        t_ext_clock();
        t_pin_reset(1'b0);
        t_pin_reset(1'b1);
        t_boot();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
